// *** rtl/bcu_bridge_ctrl.sv ***
// Contract
// - Fast back-to-back only while its bit is 1
// - Reset bit 1 asserts secondary reset output
// - Reset bit 0 keeps secondary out of reset
// - Mode 0: no report, reads all ones
// - Mode 1: non-posted PCI master abort gives UR
// - Mode 1: link UR gives PCI target abort
// - Mode 1: posted write abort signals error
// - Full decode bit only matters with VGA enable
// - Full decode 0 ignores address bits 15:10
// - Full decode 1 checks address bits 15:10
// - Bits 7, 6, 5 hold fbb, reset, mode
// - Bit 4 holds VGA full decode, read/write
// - VGA I/O: top zero, 3B0-3BB or 3C0-3DF
// - Bit 3 VGA enable forwards VGA accesses
`timescale 1ns/1ps
`include "bcu_defines.svh"

module bcu_bridge_ctrl (
	input  wire logic                 REF_CLK,
	input  wire logic                 RSTN,
	input  wire logic [`BCU_AW-1:0]   S_AXI_AWADDR,
	input  wire logic                 S_AXI_AWVALID,
	output logic                      S_AXI_AWREADY,
	input  wire logic [`BCU_DW-1:0]   S_AXI_WDATA,
	input  wire logic [3:0]           S_AXI_WSTRB,
	input  wire logic                 S_AXI_WVALID,
	output logic                      S_AXI_WREADY,
	output logic [1:0]                S_AXI_BRESP,
	output logic                      S_AXI_BVALID,
	input  wire logic                 S_AXI_BREADY,
	input  wire logic [`BCU_AW-1:0]   S_AXI_ARADDR,
	input  wire logic                 S_AXI_ARVALID,
	output logic                      S_AXI_ARREADY,
	output logic [`BCU_DW-1:0]        S_AXI_RDATA,
	output logic [1:0]                S_AXI_RRESP,
	output logic                      S_AXI_RVALID,
	input  wire logic                 S_AXI_RREADY,
	output logic                      IRQ,
	output logic                      FAST_B2B_ENABLE,
	output logic                      SECONDARY_RESET_OUT_N,
	input  wire logic                 DEC_VALID,
	input  wire logic                 DEC_IS_IO,
	input  wire logic [31:0]          DEC_ADDR,
	output logic                      DEC_DONE,
	output logic                      VGA_HIT,
	input  wire logic                 PCI_MABORT,
	input  wire logic                 PCI_MABORT_WRITE,
	input  wire logic                 PCI_MABORT_POSTED,
	input  wire logic                 LINK_UR,
	input  wire logic                 LINK_UR_READ,
	output logic                      LINK_UR_CPL,
	output logic                      PCI_TARGET_ABORT,
	output logic                      ABORT_RDATA_VALID,
	output logic [`BCU_DW-1:0]        ABORT_RDATA,
	output logic                      WRITE_DISCARD,
	output logic                      POSTED_WRITE_ERR
);

	bcu_pkg::bcu_state_t s;
	bcu_pkg::bcu_state_t next_s;
	logic                do_write;
	logic                master_abort_mode;
	logic                vga_en;
	logic                full_dec;
	logic [`BCU_IO_LO_MSB:0] io_lo;
	logic                io_hit;
	logic                mem_hit;
	logic [`BCU_NEV-1:0] ev;
	logic [`BCU_NEV-1:0] clr;

	////////////////////////////////////////////////////////////////////
	// Control bits and decode
	assign master_abort_mode      = s.ctrl[`BCU_BIT_MAM];
	assign vga_en   = s.ctrl[`BCU_BIT_VGA];
	assign full_dec = s.ctrl[`BCU_BIT_VGA_FULL_DECODE];
	assign io_lo    = DEC_ADDR[`BCU_IO_LO_MSB:0];
	assign io_hit   = DEC_IS_IO
		&& DEC_ADDR[`BCU_IO_TOP_MSB:`BCU_IO_TOP_LSB] == `BCU_IO_TOP_Z
		&& ((io_lo >= `BCU_VGA_A_LO && io_lo <= `BCU_VGA_A_HI)
		|| (io_lo >= `BCU_VGA_B_LO && io_lo <= `BCU_VGA_B_HI))
		&& (!full_dec
		|| DEC_ADDR[`BCU_ALIAS_MSB:`BCU_ALIAS_LSB] == `BCU_VGA_ALIAS_Z);
	assign mem_hit  = !DEC_IS_IO
		&& DEC_ADDR >= `BCU_VGA_MEM_LO
		&& DEC_ADDR <= `BCU_VGA_MEM_HI;

	assign do_write = s.aw_got && s.w_got && !s.bvalid;

	////////////////////////////////////////////////////////////////////
	// Interrupt events and clears, one per bit
	genvar gi;
	generate
		for (gi = 0; gi < `BCU_NEV; gi++) begin : g_ev
			assign clr[gi] = do_write && s.aw_addr == `BCU_OFS_ICLR
				&& s.wstrb[`BCU_STRB0] && s.wdata[gi];
		end
	endgenerate
	assign ev[`BCU_EV_MABORT]  = PCI_MABORT;
	assign ev[`BCU_EV_UR]      = LINK_UR;
	assign ev[`BCU_EV_POSTERR] = PCI_MABORT && PCI_MABORT_POSTED && master_abort_mode;

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_s = s;
		// Write address and data, either order
		if (S_AXI_AWVALID && s.awready) begin
			next_s.aw_got  = 1'b1;
			next_s.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = S_AXI_WDATA;
			next_s.wstrb = S_AXI_WSTRB;
		end
		if (s.bvalid && S_AXI_BREADY) begin
			next_s.bvalid = 1'b0;
		end
		if (do_write) begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = `BCU_RESP_OKAY;
			unique case (s.aw_addr)
				`BCU_OFS_CTRL: begin
					if (s.wstrb[`BCU_STRB0]) begin
						next_s.ctrl[`BCU_BYTE0_MSB:0] =
							s.wdata[`BCU_BYTE0_MSB:0]
							& `BCU_CTRL_WMASK;
					end
				end
				`BCU_OFS_IEN: begin
					if (s.wstrb[`BCU_STRB0]) begin
						next_s.int_en = s.wdata[`BCU_NEV-1:0];
					end
				end
				`BCU_OFS_ISTAT, `BCU_OFS_ICLR: begin
				end
				default: begin
					next_s.bresp = `BCU_RESP_SLVERR;
				end
			endcase
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready  = !next_s.w_got && !next_s.bvalid;

		// Read channel
		if (s.rvalid && S_AXI_RREADY) begin
			next_s.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = `BCU_RESP_OKAY;
			next_s.rdata  = '0;
			unique case (S_AXI_ARADDR)
				`BCU_OFS_CTRL: begin
					next_s.rdata[`BCU_CTRL_W-1:0] = s.ctrl;
				end
				`BCU_OFS_ISTAT: begin
					next_s.rdata[`BCU_NEV-1:0] = s.int_stat;
				end
				`BCU_OFS_IEN: begin
					next_s.rdata[`BCU_NEV-1:0] = s.int_en;
				end
				`BCU_OFS_ICLR: begin
				end
				default: begin
					next_s.rresp = `BCU_RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = !next_s.rvalid;

		// Sticky status, set wins over clear
		next_s.int_stat = (s.int_stat & ~clr) | ev;
		next_s.irq      = |(next_s.int_stat & next_s.int_en);

		// Secondary reset follows its bit for as long as it is set
		next_s.secondary_bus_reset_n = !s.ctrl[`BCU_BIT_SECONDARY_BUS_RESET];

		// VGA decode, gated by the enable bit
		next_s.dec_done = DEC_VALID;
		if (DEC_VALID) begin
			next_s.vga_hit = vga_en && (io_hit || mem_hit);
		end

		// Master abort and unsupported request handling
		next_s.ur_cpl     = 1'b0;
		next_s.tabort     = 1'b0;
		next_s.ones_valid = 1'b0;
		next_s.ones_data  = '0;
		next_s.wr_discard = 1'b0;
		next_s.post_err   = 1'b0;
		if (PCI_MABORT) begin
			if (!master_abort_mode) begin
				next_s.ones_valid = !PCI_MABORT_WRITE;
				next_s.wr_discard = PCI_MABORT_WRITE;
			end else if (PCI_MABORT_POSTED) begin
				next_s.post_err   = 1'b1;
				next_s.wr_discard = 1'b1;
			end else begin
				next_s.ur_cpl = 1'b1;
			end
		end
		if (LINK_UR) begin
			if (master_abort_mode) begin
				next_s.tabort = 1'b1;
			end else begin
				next_s.ones_valid = next_s.ones_valid || LINK_UR_READ;
				next_s.wr_discard = next_s.wr_discard || !LINK_UR_READ;
			end
		end
		if (next_s.ones_valid) begin
			next_s.ones_data = `BCU_ALL_ONES;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s        <= '0;
			s.ctrl   <= `BCU_CTRL_RST;
			s.secondary_bus_reset_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign S_AXI_AWREADY         = s.awready;
	assign S_AXI_WREADY          = s.wready;
	assign S_AXI_BVALID          = s.bvalid;
	assign S_AXI_BRESP           = s.bresp;
	assign S_AXI_ARREADY         = s.arready;
	assign S_AXI_RVALID          = s.rvalid;
	assign S_AXI_RRESP           = s.rresp;
	assign S_AXI_RDATA           = s.rdata;
	assign IRQ                   = s.irq;
	assign FAST_B2B_ENABLE       = s.ctrl[`BCU_BIT_FBB];
	assign SECONDARY_RESET_OUT_N = s.secondary_bus_reset_n;
	assign DEC_DONE              = s.dec_done;
	assign VGA_HIT               = s.vga_hit;
	assign LINK_UR_CPL           = s.ur_cpl;
	assign PCI_TARGET_ABORT      = s.tabort;
	assign ABORT_RDATA_VALID     = s.ones_valid;
	assign ABORT_RDATA           = s.ones_data;
	assign WRITE_DISCARD         = s.wr_discard;
	assign POSTED_WRITE_ERR      = s.post_err;

	////////////////////////////////////////////////////////////////////
	// Checks
	chk_fbb_write: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		do_write && s.aw_addr == `BCU_OFS_CTRL && s.wstrb[`BCU_STRB0]
		|=> FAST_B2B_ENABLE == $past(s.wdata[`BCU_BIT_FBB]))
		else $error("fast back-to-back bit not written");

	chk_fbb_stable: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		!do_write |=> $stable(FAST_B2B_ENABLE))
		else $error("fast back-to-back bit changed without a write");

	chk_secondary_bus_reset_assert: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		s.ctrl[`BCU_BIT_SECONDARY_BUS_RESET] |=> !SECONDARY_RESET_OUT_N)
		else $error("secondary reset not asserted");

	chk_secondary_bus_reset_release: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		!s.ctrl[`BCU_BIT_SECONDARY_BUS_RESET] |=> SECONDARY_RESET_OUT_N)
		else $error("secondary reset held while bit clear");

	chk_mam0_ones: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		PCI_MABORT && !master_abort_mode && !PCI_MABORT_WRITE
		|=> ABORT_RDATA_VALID && ABORT_RDATA == `BCU_ALL_ONES
		&& !LINK_UR_CPL && !POSTED_WRITE_ERR)
		else $error("mode 0 read abort did not return all ones");

	chk_mam0_discard: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		PCI_MABORT && !master_abort_mode && PCI_MABORT_WRITE
		|=> WRITE_DISCARD && !LINK_UR_CPL && !POSTED_WRITE_ERR)
		else $error("mode 0 write abort not discarded quietly");

	chk_mam1_ur: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		PCI_MABORT && master_abort_mode && !PCI_MABORT_POSTED
		|=> LINK_UR_CPL && !ABORT_RDATA_VALID)
		else $error("mode 1 abort gave no UR completion");

	chk_ur_tabort: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		LINK_UR |=> PCI_TARGET_ABORT == $past(master_abort_mode))
		else $error("target abort does not follow UR and mode");

	chk_posted_err: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		PCI_MABORT && PCI_MABORT_POSTED
		|=> POSTED_WRITE_ERR == $past(master_abort_mode))
		else $error("posted write error signalling wrong");

	chk_vga_gate: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		DEC_VALID && !vga_en |=> DEC_DONE && !VGA_HIT)
		else $error("VGA hit while VGA enable clear");

	chk_vga_alias: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		DEC_VALID && vga_en && !full_dec && DEC_IS_IO
		&& DEC_ADDR[`BCU_IO_TOP_MSB:`BCU_IO_TOP_LSB] == `BCU_IO_TOP_Z
		&& io_lo == `BCU_VGA_B_HI |=> VGA_HIT)
		else $error("aliased VGA address not decoded");

	chk_vga_full: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		DEC_VALID && vga_en && full_dec && DEC_IS_IO
		&& DEC_ADDR[`BCU_ALIAS_MSB:`BCU_ALIAS_LSB] != `BCU_VGA_ALIAS_Z
		|=> !VGA_HIT)
		else $error("full decode accepted an alias");

	chk_vga_top: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		DEC_VALID && DEC_IS_IO
		&& DEC_ADDR[`BCU_IO_TOP_MSB:`BCU_IO_TOP_LSB] != `BCU_IO_TOP_Z
		|=> !VGA_HIT)
		else $error("VGA hit above the first 64K of I/O space");

	chk_mem_hit: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		DEC_VALID && vga_en && !DEC_IS_IO
		&& DEC_ADDR >= `BCU_VGA_MEM_LO && DEC_ADDR <= `BCU_VGA_MEM_HI
		|=> VGA_HIT)
		else $error("VGA memory access not decoded");

	chk_stat_mabort: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		PCI_MABORT |=> s.int_stat[`BCU_EV_MABORT])
		else $error("master abort did not set its status bit");

	chk_stat_ur: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		LINK_UR |=> s.int_stat[`BCU_EV_UR])
		else $error("link UR did not set its status bit");

	chk_stat_clear: assert property (
		@(posedge REF_CLK) disable iff (!RSTN)
		do_write && s.aw_addr == `BCU_OFS_ICLR && s.wstrb[`BCU_STRB0]
		&& s.wdata[`BCU_EV_UR] && !LINK_UR |=> !s.int_stat[`BCU_EV_UR])
		else $error("status bit not cleared");

	chk_irq_level: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		IRQ == |(s.int_stat & s.int_en))
		else $error("interrupt output disagrees with status");

	chk_bvalid_hold: assert property (@(posedge REF_CLK) disable iff (!RSTN)
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped before ready");

endmodule // bcu_bridge_ctrl

// *** rtl/bcu_defines.svh ***
`ifndef BCU_DEFINES_SVH
`define BCU_DEFINES_SVH

// Register bus
`define BCU_AW           8
`define BCU_DW           32
`define BCU_OFS_CTRL     8'h00
`define BCU_OFS_ISTAT    8'h04
`define BCU_OFS_ICLR     8'h08
`define BCU_OFS_IEN      8'h0c
`define BCU_RESP_OKAY    2'h0
`define BCU_RESP_SLVERR  2'h2

// Bridge control fields
`define BCU_CTRL_W       16
`define BCU_CTRL_RST     16'h0000
`define BCU_CTRL_WMASK   8'hf8
`define BCU_BIT_FBB      7
`define BCU_BIT_SECONDARY_BUS_RESET     6
`define BCU_BIT_MAM      5
`define BCU_BIT_VGA_FULL_DECODE    4
`define BCU_BIT_VGA      3

// Interrupt events
`define BCU_NEV          3
`define BCU_EV_MABORT    0
`define BCU_EV_UR        1
`define BCU_EV_POSTERR   2

// Abort data and VGA decode ranges
`define BCU_ALL_ONES     32'hffffffff
`define BCU_VGA_A_LO     10'h3b0
`define BCU_VGA_A_HI     10'h3bb
`define BCU_VGA_B_LO     10'h3c0
`define BCU_VGA_B_HI     10'h3df
`define BCU_VGA_ALIAS_Z  6'h00
`define BCU_IO_TOP_Z     16'h0000
`define BCU_VGA_MEM_LO   32'h000a0000
`define BCU_VGA_MEM_HI   32'h000bffff

// Field positions of bus words and decode addresses
`define BCU_BYTE0_MSB    7
`define BCU_STRB0        0
`define BCU_IO_LO_MSB    9
`define BCU_ALIAS_MSB    15
`define BCU_ALIAS_LSB    10
`define BCU_IO_TOP_MSB   31
`define BCU_IO_TOP_LSB   16

`endif

// *** rtl/bcu_pkg.sv ***
package bcu_pkg;
`include "bcu_defines.svh"

	typedef struct packed {
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [`BCU_DW-1:0]      rdata;
		logic                    aw_got;
		logic [`BCU_AW-1:0]      aw_addr;
		logic                    w_got;
		logic [`BCU_DW-1:0]      wdata;
		logic [3:0]              wstrb;
		logic [`BCU_CTRL_W-1:0]  ctrl;
		logic [`BCU_NEV-1:0]     int_stat;
		logic [`BCU_NEV-1:0]     int_en;
		logic                    irq;
		logic                    secondary_bus_reset_n;
		logic                    dec_done;
		logic                    vga_hit;
		logic                    ur_cpl;
		logic                    tabort;
		logic                    ones_valid;
		logic [`BCU_DW-1:0]      ones_data;
		logic                    wr_discard;
		logic                    post_err;
	} bcu_state_t;

endpackage

// *** tb/bcu_pci_master.sv ***
`timescale 1ns/1ps
module bcu_pci_master (
	input  wire logic        clk,
	output logic             mabort,
	output logic             ma_write,
	output logic             ma_posted,
	output logic             dec_valid,
	output logic             dec_io,
	output logic [31:0]      dec_addr
);
	initial begin
		{mabort, ma_write, ma_posted, dec_valid, dec_io} = 5'h00;
		dec_addr = 32'h0;
	end
	////////////////////////////////////////////////////////////
	// One-cycle abort report; qualifiers flip once released
	task automatic abort(input logic w, input logic p);
		@(posedge clk);
		{mabort, ma_write, ma_posted} <= {1'h1, w, p};
		@(posedge clk);
		{mabort, ma_write, ma_posted} <= {1'h0, ~w, ~p};
	endtask
	// One-cycle decode request; address flips once released
	task automatic decode(input logic io, input logic [31:0] a);
		@(posedge clk);
		{dec_valid, dec_io, dec_addr} <= {1'h1, io, a};
		@(posedge clk);
		{dec_valid, dec_io, dec_addr} <= {1'h0, ~io, ~a};
	endtask
endmodule // bcu_pci_master

// *** tb/bridge_control_bits_upper_tb.sv ***
`timescale 1ns/1ps
`include "bcu_defines.svh"
module bridge_control_bits_upper_tb;
	logic        ck = 1'h0, rstn = 1'h0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdt, odat, daddr, rd_val;
	logic        awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
	logic        lur = 1'h0, lurd = 1'h0, awr, wr_, bv, arr, rv, irq, fbb;
	logic        srn, dv, dio, done, hit, ma, maw, map, urc, ta, ov, dis, pe;
	logic [1:0]  br, rr, resp;
	int          mismatches = 0, samples_checked = 0;
	always #5 ck = ~ck;
	bcu_bridge_ctrl u_dut (.REF_CLK(ck), .RSTN(rstn),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr_), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(brd), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .IRQ(irq),
		.FAST_B2B_ENABLE(fbb), .SECONDARY_RESET_OUT_N(srn),
		.DEC_VALID(dv), .DEC_IS_IO(dio), .DEC_ADDR(daddr), .DEC_DONE(done),
		.VGA_HIT(hit), .PCI_MABORT(ma), .PCI_MABORT_WRITE(maw),
		.PCI_MABORT_POSTED(map), .LINK_UR(lur), .LINK_UR_READ(lurd),
		.LINK_UR_CPL(urc), .PCI_TARGET_ABORT(ta), .ABORT_RDATA_VALID(ov),
		.ABORT_RDATA(odat), .WRITE_DISCARD(dis), .POSTED_WRITE_ERR(pe));
	bcu_pci_master u_pci (.clk(ck), .mabort(ma), .ma_write(maw),
		.ma_posted(map), .dec_valid(dv), .dec_io(dio), .dec_addr(daddr));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ck);
		{awa, wd, awv, wv, brd} <= {a, d, 3'h7};
		do begin
			@(posedge ck);
			if (awr)
				awv <= 1'h0;
			if (wr_)
				wv <= 1'h0;
		end while (bv !== 1'h1);
		brd <= 1'h0;
		resp = br;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ck);
		{ara, arv, rrd} <= {a, 2'h3};
		do begin
			@(posedge ck);
			if (arr)
				arv <= 1'h0;
		end while (rv !== 1'h1);
		rrd <= 1'h0;
		rd_val = rdt;
		resp = rr;
	endtask
	// Unsupported-request completion arriving from the link
	task automatic link_ur(input logic r);
		@(posedge ck);
		{lur, lurd} <= {1'h1, r};
		@(posedge ck);
		{lur, lurd} <= {1'h0, ~r};
	endtask
	task automatic dec(input logic [7:0] c, input logic io,
		input logic [31:0] a, input logic e);
		wr(`BCU_OFS_CTRL, {24'h0, c});
		u_pci.decode(io, a);
		#1;
		chk(done, 1'h1);
		chk(hit, e);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ck);
		mismatches++;
		$display("CHECK FAILED t=%0t watchdog", $time);
		conclude;
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ck);
		rstn <= 1'h1;
		rd(`BCU_OFS_CTRL);
		chk(rd_val, 32'h0);
		chk(fbb, 1'h0);
		chk(srn, 1'h1);
		wr(`BCU_OFS_CTRL, 32'hff);
		#1;
		chk(fbb, 1'h1);
		chk(srn, 1'h0);
		rd(`BCU_OFS_CTRL);
		chk(rd_val, 32'hf8);
		repeat (4) @(posedge ck);
		#1;
		chk(srn, 1'h0);
		wr(`BCU_OFS_CTRL, 32'h0);
		#1;
		chk(srn, 1'h1);
		chk(fbb, 1'h0);
		$display("test control done");
		u_pci.abort(1'h0, 1'h0);
		#1;
		chk({ov, urc}, 2'h2);
		chk(odat, `BCU_ALL_ONES);
		u_pci.abort(1'h1, 1'h1);
		#1;
		chk({dis, pe}, 2'h2);
		wr(`BCU_OFS_CTRL, 32'h20);
		u_pci.abort(1'h0, 1'h0);
		#1;
		chk({urc, ov}, 2'h2);
		u_pci.abort(1'h1, 1'h1);
		#1;
		chk(pe, 1'h1);
		link_ur(1'h1);
		#1;
		chk({ta, ov}, 2'h2);
		$display("test abort done");
		dec(8'h00, 1'h1, 32'h3c0, 1'h0);
		dec(8'h10, 1'h1, 32'h3b0, 1'h0);
		dec(8'h08, 1'h1, 32'h7fb0, 1'h1);
		dec(8'h08, 1'h1, 32'hfdf, 1'h1);
		dec(8'h18, 1'h1, 32'h7fb0, 1'h0);
		dec(8'h18, 1'h1, 32'h3df, 1'h1);
		dec(8'h08, 1'h1, 32'h3bc, 1'h0);
		dec(8'h08, 1'h1, 32'h3e0, 1'h0);
		dec(8'h08, 1'h1, 32'h103c0, 1'h0);
		dec(8'h08, 1'h0, 32'ha0000, 1'h1);
		$display("test decode done");
		wr(`BCU_OFS_IEN, 32'h7);
		#1;
		chk(irq, 1'h1);
		rd(`BCU_OFS_ISTAT);
		chk(rd_val, 32'h7);
		wr(`BCU_OFS_ICLR, 32'h7);
		#1;
		chk(irq, 1'h0);
		wr(`BCU_OFS_IEN, 32'h2);
		u_pci.abort(1'h1, 1'h0);
		repeat (2) @(posedge ck);
		#1;
		chk(irq, 1'h0);
		link_ur(1'h0);
		repeat (2) @(posedge ck);
		#1;
		chk(irq, 1'h1);
		rd(`BCU_OFS_ISTAT);
		chk(rd_val, 32'h3);
		rd(8'h40);
		chk(resp, `BCU_RESP_SLVERR);
		wr(8'h40, 32'h1);
		chk(resp, `BCU_RESP_SLVERR);
		$display("test registers done");
		conclude;
	end
endmodule // bridge_control_bits_upper_tb
